// ### logic/sfpe_pkg.sv
// Shared constants and types for the serial flash program and erase sequencer.
// Assumes a 125 MHz core clock and a host link much slower than that clock.
package sfpe_pkg;

  // ---------------------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG = 8'h32;
  localparam logic [7:0] OP_FAST_PROG = 8'hF2;
  localparam logic [7:0] OP_SECT_ERASE = 8'h20;
  localparam logic [7:0] OP_BLK32_ERASE = 8'h52;

  // ---------------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------------
  localparam int unsigned PAGE_BYTES      = 256;
  localparam int unsigned MEM_ADDR_W      = 22;
  localparam logic [24:0] MEM_BYTES       = 25'h040_0000;
  localparam logic [23:0] SECTOR_BYTES    = 24'h00_1000;
  localparam logic [23:0] BLOCK32_BYTES   = 24'h00_8000;
  localparam logic [23:0] PROT_UNIT_BYTES = 24'h01_0000;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CORE_CLK_MHZ          = 125;
  localparam int unsigned PAGE_PROGRAM_TIME_US  = 600;
  localparam int unsigned SECTOR_ERASE_TIME_MS  = 50;
  localparam int unsigned BLOCK_ERASE_TIME_MS   = 150;
  localparam int unsigned PAGE_PROGRAM_CYCLES   = PAGE_PROGRAM_TIME_US * CORE_CLK_MHZ;
  localparam int unsigned SECTOR_ERASE_CYCLES   = SECTOR_ERASE_TIME_MS * 1000 * CORE_CLK_MHZ;
  localparam int unsigned BLOCK_ERASE_CYCLES    = BLOCK_ERASE_TIME_MS * 1000 * CORE_CLK_MHZ;

  // ---------------------------------------------------------------------------
  // States
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_CMD,
    PH_ADDR,
    PH_DATA,
    PH_DONE,
    PH_SKIP
  } sfpe_phase_t;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_PROG,
    OP_ERASE
  } sfpe_op_t;

endpackage

// ### logic/sfpe_page_buf.sv
// Page buffer: one byte and one written flag per page location, in flip-flops.
// Assumes writes and clears come from logic on the same clock.
module sfpe_page_buf #(
  parameter int unsigned IDX_W  = 8,
  parameter int unsigned DATA_W = 8
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // Fill side
  input  wire logic              clear,
  input  wire logic              wr_en,
  input  wire logic [IDX_W-1:0]  wr_idx,
  input  wire logic [DATA_W-1:0] wr_data,
  // Drain side
  input  wire logic [IDX_W-1:0]  rd_idx,
  output logic      [DATA_W-1:0] rd_data,
  output logic                   rd_valid
);

  localparam int unsigned DEPTH = 1 << IDX_W;

  typedef struct packed {
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    logic [DEPTH-1:0]             written;
  } sfpe_buf_state_t;

  sfpe_buf_state_t q;
  sfpe_buf_state_t d;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // A later byte at the same index simply overwrites the earlier one.
  always_comb begin
    d = q;
    if (clear) begin
      d.written = '0;
    end
    if (wr_en) begin
      d.mem[wr_idx]     = wr_data;
      d.written[wr_idx] = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rd_data  = q.mem[rd_idx];
  assign rd_valid = q.written[rd_idx];

endmodule

// ### logic/sfpe_seq.sv
// Program and erase command sequencer of a serial NOR flash, host link side.
// Assumes sclk runs at most one eighth of core_clk and the array accepts one
// write per cycle on the array port.
module sfpe_seq
  import sfpe_pkg::*;
#(
  parameter int unsigned PP_CYCLES = PAGE_PROGRAM_CYCLES,
  parameter int unsigned SE_CYCLES = SECTOR_ERASE_CYCLES,
  parameter int unsigned BE_CYCLES = BLOCK_ERASE_CYCLES
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Host link pins
  input  wire logic        chip_select_n,
  input  wire logic        serial_clk,
  input  wire logic        quad_line_0,
  input  wire logic        quad_line_1,
  input  wire logic        quad_line_2,
  input  wire logic        quad_line_3,
  // Status bits
  input  wire logic        write_enable_set,
  input  wire logic        write_disable,
  input  wire logic        quad_enable_bit,
  input  wire logic        block_protect_bit4,
  input  wire logic        block_protect_bit3,
  input  wire logic        block_protect_bit2,
  input  wire logic        block_protect_bit1,
  input  wire logic        block_protect_bit0,
  output logic             write_in_progress_flag,
  output logic             write_enable_latch,
  output logic             frame_rejected,
  // Array port
  output logic             array_wr_en,
  output logic [23:0]      array_wr_addr,
  output logic [7:0]       array_wr_data,
  output logic             array_erase_en,
  output logic [23:0]      array_erase_addr,
  output logic             array_erase_32k
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        sclk_m;
    logic        sclk_s;
    logic        sclk_d;
    logic        csn_m;
    logic        csn_s;
    logic        csn_d;
    logic [3:0]  dat_m;
    logic [3:0]  dat_s;
    sfpe_phase_t phase;
    logic        claimed;
    logic [7:0]  shift;
    logic [2:0]  bit_cnt;
    logic [1:0]  addr_cnt;
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [7:0]  data_cnt;
    logic        data_seen;
    sfpe_op_t    op;
    logic [31:0] timer;
    logic [8:0]  walk_idx;
    logic        busy;
    logic        we_latch;
    logic        rejected;
    logic        wr_en;
    logic [23:0] wr_addr;
    logic [7:0]  wr_data;
    logic        erase_en;
    logic [23:0] erase_addr;
    logic        erase_32k;
  } sfpe_state_t;

  sfpe_state_t q;
  sfpe_state_t d;

  logic       buf_clear;
  logic       buf_wr_en;
  logic [7:0] buf_wr_idx;
  logic [7:0] buf_wr_data;
  logic [7:0] buf_rd_data;
  logic       buf_rd_valid;

  // ---------------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------------
  // Protected span grows in powers of two from the top, or from the bottom when
  // bit3 is set; bit4 picks 4 KB units instead of 64 KB. Any overlap protects.
  function automatic logic sfpe_protected(input logic [4:0]  bp,
                                          input logic [23:0] base,
                                          input logic [23:0] span);
    logic [24:0] size;
    logic [24:0] last;
    logic        hit;
    size = {1'b0, (bp[4] ? SECTOR_BYTES : PROT_UNIT_BYTES)} << (bp[2:0] - 3'd1);
    last = {1'b0, base} + {1'b0, span} - 25'h000_0001;
    if (size > MEM_BYTES) begin
      size = MEM_BYTES;
    end
    if (bp[2:0] == 3'd0) begin
      hit = 1'b0;
    end else if (bp[2:0] == 3'd7) begin
      hit = 1'b1;
    end else if (bp[3]) begin
      hit = {1'b0, base} < size;
    end else begin
      hit = last >= (MEM_BYTES - size);
    end
    return hit;
  endfunction

  function automatic logic sfpe_is_prog(input logic [7:0] opc);
    return (opc == OP_PAGE_PROG) || (opc == OP_FAST_PROG) || (opc == OP_QUAD_PROG);
  endfunction

  function automatic logic sfpe_is_erase(input logic [7:0] opc);
    return (opc == OP_SECT_ERASE) || (opc == OP_BLK32_ERASE);
  endfunction

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic        sclk_rise;
    logic        cs_fall;
    logic        cs_rise;
    logic [7:0]  sh_single;
    logic [7:0]  sh_quad;
    logic        quad;
    logic        is_blk;
    logic [23:0] page_base;
    logic [23:0] erase_base;
    logic [4:0]  bp;
    logic        prog_ok;
    logic        erase_ok;
    sclk_rise  = q.sclk_s & ~q.sclk_d;
    cs_fall    = ~q.csn_s & q.csn_d;
    cs_rise    = q.csn_s & ~q.csn_d;
    sh_single  = {q.shift[6:0], q.dat_s[0]};
    sh_quad    = {q.shift[3:0], q.dat_s};
    quad       = q.opcode == OP_QUAD_PROG;
    is_blk     = q.opcode == OP_BLK32_ERASE;
    page_base  = {q.addr[23:8], 8'h00};
    erase_base = is_blk ? (q.addr & ~(BLOCK32_BYTES - 24'h00_0001))
                        : (q.addr & ~(SECTOR_BYTES - 24'h00_0001));
    bp = {block_protect_bit4, block_protect_bit3, block_protect_bit2,
          block_protect_bit1, block_protect_bit0};
    prog_ok = (q.phase == PH_DATA) && q.data_seen && (q.bit_cnt == 3'd0)
              && q.we_latch && q.claimed
              && !sfpe_protected(bp, page_base, 24'(PAGE_BYTES));
    erase_ok = (q.phase == PH_DONE) && q.we_latch && q.claimed
               && !sfpe_protected(bp, erase_base,
                                  is_blk ? BLOCK32_BYTES : SECTOR_BYTES);

    d           = q;
    buf_clear   = 1'b0;
    buf_wr_en   = 1'b0;
    buf_wr_idx  = q.addr[7:0] + q.data_cnt;
    buf_wr_data = quad ? sh_quad : sh_single;

    // Pin synchronisers.
    d.sclk_m = serial_clk;
    d.sclk_s = q.sclk_m;
    d.sclk_d = q.sclk_s;
    d.csn_m  = chip_select_n;
    d.csn_s  = q.csn_m;
    d.csn_d  = q.csn_s;
    d.dat_m  = {quad_line_3, quad_line_2, quad_line_1, quad_line_0};
    d.dat_s  = q.dat_m;

    d.rejected = 1'b0;
    d.wr_en    = 1'b0;
    d.erase_en = 1'b0;

    // Frame decoder. A frame that opens while busy is never claimed.
    if (cs_fall) begin
      d.phase     = q.busy ? PH_SKIP : PH_CMD;
      d.claimed   = 1'b0;
      d.bit_cnt   = 3'd0;
      d.addr_cnt  = 2'd0;
      d.data_cnt  = 8'h00;
      d.data_seen = 1'b0;
      buf_clear   = !q.busy;
    end else if (!q.csn_s && sclk_rise) begin
      unique case (q.phase)
        PH_CMD: begin
          d.shift   = sh_single;
          d.bit_cnt = q.bit_cnt + 3'd1;
          if (q.bit_cnt == 3'd7) begin
            d.opcode  = sh_single;
            d.claimed = sfpe_is_prog(sh_single) || sfpe_is_erase(sh_single);
            if ((sh_single == OP_QUAD_PROG) && !quad_enable_bit) begin
              d.phase = PH_SKIP;
            end else if (sfpe_is_prog(sh_single) || sfpe_is_erase(sh_single)) begin
              d.phase = PH_ADDR;
            end else begin
              d.phase = PH_SKIP;
            end
          end
        end
        PH_ADDR: begin
          d.shift   = sh_single;
          d.bit_cnt = q.bit_cnt + 3'd1;
          if (q.bit_cnt == 3'd7) begin
            d.addr     = {q.addr[15:0], sh_single};
            d.addr_cnt = q.addr_cnt + 2'd1;
            if (q.addr_cnt == 2'd2) begin
              d.phase = sfpe_is_erase(q.opcode) ? PH_DONE : PH_DATA;
            end
          end
        end
        PH_DATA: begin
          if (quad) begin
            d.shift   = sh_quad;
            d.bit_cnt = q.bit_cnt + 3'd4;
            buf_wr_en = q.bit_cnt == 3'd4;
          end else begin
            d.shift   = sh_single;
            d.bit_cnt = q.bit_cnt + 3'd1;
            buf_wr_en = q.bit_cnt == 3'd7;
          end
          if (buf_wr_en) begin
            d.data_cnt  = q.data_cnt + 8'h01;
            d.data_seen = 1'b1;
          end
        end
        PH_DONE: begin
          d.phase = PH_SKIP;
        end
        PH_SKIP: begin
          d.phase = PH_SKIP;
        end
        PH_IDLE: begin
          d.phase = PH_IDLE;
        end
      endcase
    end

    // Self-timed cycle. The whole page image is walked before the timer ends,
    // so the array sees every written byte and no unwritten one.
    unique case (q.op)
      OP_IDLE: begin
        d.op = OP_IDLE;
      end
      OP_PROG: begin
        if (!q.walk_idx[8]) begin
          d.wr_en    = buf_rd_valid;
          d.wr_addr  = {q.addr[23:8], q.walk_idx[7:0]};
          d.wr_data  = buf_rd_data;
          d.walk_idx = q.walk_idx + 9'd1;
        end
      end
      OP_ERASE: begin
        d.op = OP_ERASE;
      end
    endcase
    if (q.op != OP_IDLE) begin
      d.timer = q.timer - 32'd1;
      if (q.timer == 32'd1) begin
        d.op  = OP_IDLE;
        d.busy = 1'b0;
      end
    end

    // Frame end: start a cycle or drop the command.
    if (cs_rise) begin
      d.phase = PH_IDLE;
      if (prog_ok) begin
        d.op       = OP_PROG;
        d.timer    = 32'(PP_CYCLES);
        d.walk_idx = 9'd0;
        d.busy     = 1'b1;
        d.we_latch = 1'b0;
      end else if (erase_ok) begin
        d.op         = OP_ERASE;
        d.timer      = is_blk ? 32'(BE_CYCLES) : 32'(SE_CYCLES);
        d.busy       = 1'b1;
        d.we_latch   = 1'b0;
        d.erase_en   = 1'b1;
        d.erase_addr = erase_base;
        d.erase_32k  = is_blk;
      end else begin
        d.rejected = q.claimed;
      end
    end

    // Write enable latch: a set arriving with a clear wins.
    if (write_disable) begin
      d.we_latch = 1'b0;
    end
    if (write_enable_set) begin
      d.we_latch = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      q        <= '0;
      q.sclk_m <= 1'b0;
      q.csn_m  <= 1'b1;
      q.csn_s  <= 1'b1;
      q.csn_d  <= 1'b1;
      q.phase  <= PH_IDLE;
      q.op     <= OP_IDLE;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------------------
  // Page buffer
  // ---------------------------------------------------------------------------
  sfpe_page_buf #(
    .IDX_W  (8),
    .DATA_W (8)
  ) u_page_buf (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (buf_clear),
    .wr_en    (buf_wr_en),
    .wr_idx   (buf_wr_idx),
    .wr_data  (buf_wr_data),
    .rd_idx   (q.walk_idx[7:0]),
    .rd_data  (buf_rd_data),
    .rd_valid (buf_rd_valid)
  );

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign write_in_progress_flag = q.busy;
  assign write_enable_latch     = q.we_latch;
  assign frame_rejected         = q.rejected;
  assign array_wr_en            = q.wr_en;
  assign array_wr_addr          = q.wr_addr;
  assign array_wr_data          = q.wr_data;
  assign array_erase_en         = q.erase_en;
  assign array_erase_addr       = q.erase_addr;
  assign array_erase_32k        = q.erase_32k;

endmodule

// ### verif/sfpe_seq_assertions.sv
// Concurrent checks on the program and erase sequencer ports.
// Assumes it is bound to sfpe_seq with the same shortened cycle counts.
module sfpe_seq_assertions #(
  parameter int unsigned PP_CYCLES = 300,
  parameter int unsigned SE_CYCLES = 400,
  parameter int unsigned BE_CYCLES = 500
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Status
  input wire logic        write_enable_set,
  input wire logic        write_in_progress_flag,
  input wire logic        write_enable_latch,
  input wire logic        frame_rejected,
  // Array port
  input wire logic        array_wr_en,
  input wire logic        array_erase_en,
  input wire logic [23:0] array_erase_addr,
  input wire logic        array_erase_32k
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // --------------------------------------------------------------------------
  // Busy length counter
  // --------------------------------------------------------------------------
  logic [31:0] busy_q;
  always_ff @(posedge core_clk) begin
    busy_q <= (rst || !write_in_progress_flag) ? 32'h0000_0000 : busy_q + 32'h0000_0001;
  end

  // --------------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------------
  sequence s_start;
    $rose(write_in_progress_flag);
  endsequence
  sequence s_reject;
    frame_rejected;
  endsequence

  property p_start_clears_latch;
    s_start |-> !write_enable_latch;
  endproperty
  property p_start_needs_latch;
    s_start |-> $past(write_enable_latch);
  endproperty
  property p_busy_length;
    $fell(write_in_progress_flag) |->
      (busy_q == PP_CYCLES) || (busy_q == SE_CYCLES) || (busy_q == BE_CYCLES);
  endproperty
  property p_erase_aligned;
    array_erase_en |-> write_in_progress_flag &&
      (array_erase_32k ? (array_erase_addr[14:0] == 15'h0000)
                       : (array_erase_addr[11:0] == 12'h000));
  endproperty
  property p_erase_once;
    array_erase_en |=> !array_erase_en [*8];
  endproperty
  property p_write_in_cycle;
    array_wr_en |-> write_in_progress_flag;
  endproperty
  property p_reject_idle;
    s_reject |-> !write_in_progress_flag;
  endproperty
  property p_reject_no_run;
    s_reject |-> ##1 (!write_in_progress_flag && !frame_rejected);
  endproperty
  property p_latch_set;
    write_enable_set && !write_in_progress_flag |=> write_enable_latch || write_in_progress_flag;
  endproperty

  a_start_clears_latch: assert property (p_start_clears_latch)
    else $error("latch still set when a cycle starts");
  a_start_needs_latch: assert property (p_start_needs_latch)
    else $error("cycle started with the latch clear");
  a_busy_length: assert property (p_busy_length)
    else $error("busy flag length differs from the timed cycle");
  a_erase_aligned: assert property (p_erase_aligned)
    else $error("erase base not aligned or outside busy");
  a_erase_once: assert property (p_erase_once)
    else $error("erase strobe repeated");
  a_write_in_cycle: assert property (p_write_in_cycle)
    else $error("array write outside a program cycle");
  a_reject_idle: assert property (p_reject_idle)
    else $error("reject pulse while busy");
  a_reject_no_run: assert property (p_reject_no_run)
    else $error("rejected frame started a cycle");
  a_latch_set: assert property (p_latch_set)
    else $error("write enable did not set the latch");
endmodule

// ### verif/sfpe_host_model.sv
// Host controller model: frames opcode, address and data on the link pins.
// Assumes a free-running core_clk paces the link; the link clock stands between frames.
module sfpe_host_model (
  // Clock
  input wire logic core_clk,
  // Link pins
  output logic     chip_select_n,
  output logic     serial_clk,
  output logic     quad_line_0,
  output logic     quad_line_1,
  output logic     quad_line_2,
  output logic     quad_line_3
);
  timeunit 1ns;
  timeprecision 100ps;
  // Five core cycles per half period keeps clear of the one-eighth limit.
  localparam int HALF = 5;

  initial begin
    chip_select_n = 1'b1;
    serial_clk = 1'b0;
    {quad_line_3, quad_line_2, quad_line_1, quad_line_0} = 4'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic put(input logic [3:0] v);
    {quad_line_3, quad_line_2, quad_line_1, quad_line_0} = v;
    tick(HALF);
    serial_clk = 1'b1;
    tick(HALF);
    serial_clk = 1'b0;
  endtask

  task automatic send(input logic [7:0] op, input logic [23:0] a, input int n,
                      input int extra, input bit quad, input logic [7:0] base);
    logic [7:0] b;
    int         i;
    int         k;
    chip_select_n = 1'b0;
    for (i = 0; i < 4 + n; i++) begin
      b = (i == 0) ? op : (i < 4) ? a[8*(3-i) +: 8] : base + 8'(i - 4);
      if (quad && i >= 4) begin
        put(b[7:4]);
        put(b[3:0]);
      end else begin
        for (k = 7; k >= 0; k--) put({~b[k], b[k], ~b[k], b[k]});
      end
    end
    for (k = 0; k < extra; k++) put(4'h5);
    tick(HALF);
    chip_select_n = 1'b1;
    {quad_line_3, quad_line_2, quad_line_1, quad_line_0} =
      ~{quad_line_3, quad_line_2, quad_line_1, quad_line_0};
  endtask
endmodule

// ### verif/tb.sv
// Self-checking bench for the program and erase sequencer.
// Assumes the host model drives the link and the bench drives the status bits.
module tb import sfpe_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0, rst = 1'b1, write_enable_set = 1'b0, write_disable = 1'b0, quad_en = 1'b0;
  logic [4:0] bp = 5'h00;
  logic chip_select_n, serial_clk, quad_line_0, quad_line_1, quad_line_2, quad_line_3;
  logic write_in_progress_flag, write_enable_latch, frame_rejected;
  logic array_wr_en, array_erase_en, array_erase_32k;
  logic [23:0] array_wr_addr, array_erase_addr;
  logic [7:0] array_wr_data;
  logic [7:0] wr_mem [int];
  logic [24:0] er_last;
  int n_fail = 0, num_checks = 0, wr_n = 0, er_n = 0, rej_n = 0;

  always #4 core_clk = ~core_clk;

  sfpe_seq #(.PP_CYCLES(300), .SE_CYCLES(400), .BE_CYCLES(500)) dut_u (
    .core_clk(core_clk), .rst(rst), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
    .quad_line_0(quad_line_0), .quad_line_1(quad_line_1), .quad_line_2(quad_line_2),
    .quad_line_3(quad_line_3), .write_enable_set(write_enable_set),
    .write_disable(write_disable), .quad_enable_bit(quad_en), .block_protect_bit4(bp[4]),
    .block_protect_bit3(bp[3]), .block_protect_bit2(bp[2]), .block_protect_bit1(bp[1]),
    .block_protect_bit0(bp[0]), .write_in_progress_flag(write_in_progress_flag),
    .write_enable_latch(write_enable_latch), .frame_rejected(frame_rejected),
    .array_wr_en(array_wr_en), .array_wr_addr(array_wr_addr), .array_wr_data(array_wr_data),
    .array_erase_en(array_erase_en), .array_erase_addr(array_erase_addr),
    .array_erase_32k(array_erase_32k));

  sfpe_host_model h_u (
    .core_clk(core_clk), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
    .quad_line_0(quad_line_0), .quad_line_1(quad_line_1), .quad_line_2(quad_line_2),
    .quad_line_3(quad_line_3));

  // Array side is recorded rather than modelled; the last write to a byte wins.
  always @(posedge core_clk) begin
    if (array_wr_en === 1'b1) begin
      wr_mem[int'(array_wr_addr)] = array_wr_data;
      wr_n++;
    end
    if (array_erase_en === 1'b1) begin
      er_last = {array_erase_32k, array_erase_addr};
      er_n++;
    end
    if (frame_rejected === 1'b1) rej_n++;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wait_busy(input logic v);
    int t;
    t = 0;
    while (write_in_progress_flag !== v && t < 700) begin
      tick(1);
      t++;
    end
    check("busy flag level", write_in_progress_flag, v);
  endtask

  task automatic run(input logic [7:0] op, input logic [23:0] a, input int n, input int extra,
                     input bit set_latch, input bit exec, input logic [7:0] base);
    wr_mem.delete();
    wr_n = 0;
    er_n = 0;
    rej_n = 0;
    write_enable_set = set_latch;
    tick(1);
    write_enable_set = 1'b0;
    h_u.send(op, a, n, extra, op == OP_QUAD_PROG, base);
    tick(12);
    check("cycle started", write_in_progress_flag, exec);
    check("reject count", rej_n, !exec);
    if (exec) begin
      check("latch at start", write_enable_latch, 1'b0);
      wait_busy(1'b0);
    end
  endtask

  task automatic check_page(input logic [23:0] a, input int n, input logic [7:0] base);
    logic [7:0] exp [int];
    int         i;
    for (i = 0; i < n; i++) exp[int'({a[23:8], 8'(a[7:0] + i)})] = base + 8'(i);
    check("write count", wr_n, exp.size());
    foreach (exp[k]) check("page byte", wr_mem.exists(k) ? wr_mem[k] : 8'hxx, exp[k]);
  endtask

  task automatic t_program;
    run(OP_PAGE_PROG, 24'h01_23F0, 20, 0, 1, 1, 8'h40);
    check_page(24'h01_23F0, 20, 8'h40);
    run(OP_FAST_PROG, 24'h00_0305, 260, 0, 1, 1, 8'h10);
    check_page(24'h00_0305, 260, 8'h10);
    $display("test program done");
  endtask

  task automatic t_quad;
    quad_en = 1'b1;
    run(OP_QUAD_PROG, 24'h00_0410, 3, 0, 1, 1, 8'hC3);
    check_page(24'h00_0410, 3, 8'hC3);
    quad_en = 1'b0;
    run(OP_QUAD_PROG, 24'h00_0410, 3, 0, 1, 0, 8'hC3);
    check("quad refused writes", wr_n, 0);
    $display("test quad done");
  endtask

  task automatic t_refuse;
    write_enable_set = 1'b1;
    tick(1);
    write_enable_set = 1'b0;
    write_disable = 1'b1;
    tick(1);
    write_disable = 1'b0;
    tick(1);
    check("latch after disable", write_enable_latch, 1'b0);
    run(OP_PAGE_PROG, 24'h00_0500, 2, 0, 0, 0, 8'h01);
    run(OP_PAGE_PROG, 24'h00_0500, 2, 3, 1, 0, 8'h01);
    check("latch kept", write_enable_latch, 1'b1);
    run(OP_SECT_ERASE, 24'h00_5000, 0, 1, 1, 0, 8'h00);
    check("refused writes", wr_n + er_n, 0);
    $display("test refusals done");
  endtask

  task automatic t_erase;
    run(OP_SECT_ERASE, 24'h12_3456, 0, 0, 1, 1, 8'h00);
    check("sector erase", er_last, {1'b0, 24'h12_3000});
    run(OP_BLK32_ERASE, 24'h12_ABCD, 0, 0, 1, 1, 8'h00);
    check("block erase", er_last, {1'b1, 24'h12_8000});
    check("erase strobes", er_n, 1);
    $display("test erase done");
  endtask

  task automatic t_protect;
    bp = 5'h07;
    run(OP_PAGE_PROG, 24'h00_0100, 1, 0, 1, 0, 8'h22);
    run(OP_BLK32_ERASE, 24'h00_0000, 0, 0, 1, 0, 8'h00);
    bp = 5'h01;
    run(OP_PAGE_PROG, 24'h3F_0100, 1, 0, 1, 0, 8'h22);
    run(OP_SECT_ERASE, 24'h3F_F000, 0, 0, 1, 0, 8'h00);
    run(OP_PAGE_PROG, 24'h00_0100, 1, 0, 1, 1, 8'h22);
    check_page(24'h00_0100, 1, 8'h22);
    bp = 5'h19;
    run(OP_SECT_ERASE, 24'h00_0800, 0, 0, 1, 0, 8'h00);
    run(OP_SECT_ERASE, 24'h00_1000, 0, 0, 1, 1, 8'h00);
    check("bottom sector erase", er_last, {1'b0, 24'h00_1000});
    bp = 5'h00;
    $display("test protection done");
  endtask

  task automatic t_busy;
    run(OP_PAGE_PROG, 24'h00_0000, 0, 0, 0, 0, 8'h00);
    write_enable_set = 1'b1;
    tick(1);
    write_enable_set = 1'b0;
    h_u.send(OP_BLK32_ERASE, 24'h20_0000, 0, 0, 0, 8'h00);
    wait_busy(1'b1);
    rej_n = 0;
    h_u.send(OP_PAGE_PROG, 24'h00_0000, 1, 0, 0, 8'h77);
    wait_busy(1'b0);
    tick(20);
    check("busy frame reject", rej_n, 0);
    check("busy frame writes", wr_n, 0);
    $display("test busy done");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    tick(5);
    rst = 1'b0;
    tick(8);
    t_program;
    t_quad;
    t_refuse;
    t_erase;
    t_protect;
    t_busy;
    summarize;
  end

  // The longest test streams about 23k cycles and the whole run about 32k; nearly three times the whole run is ample.
  initial begin
    repeat (90000) @(posedge core_clk);
    n_fail++;
    summarize;
  end
endmodule

bind sfpe_seq sfpe_seq_assertions #(.PP_CYCLES(PP_CYCLES), .SE_CYCLES(SE_CYCLES),
  .BE_CYCLES(BE_CYCLES)) chk_u (
  .core_clk(core_clk), .rst(rst), .write_enable_set(write_enable_set),
  .write_in_progress_flag(write_in_progress_flag), .write_enable_latch(write_enable_latch),
  .frame_rejected(frame_rejected), .array_wr_en(array_wr_en),
  .array_erase_en(array_erase_en), .array_erase_addr(array_erase_addr),
  .array_erase_32k(array_erase_32k));
